// file: verilog/pfc_pkg.sv
package pfc_pkg;

   localparam int DATA_W    = 32;
   localparam int ADDR_W    = 8;
   localparam int LINES     = 16;
   localparam int IDX_W     = 4;
   localparam int WORDS     = 3;
   localparam int LRU_W     = 25;

   localparam logic [ADDR_W-1:0] OFS_ACCESS = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_WORD1  = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_WORD2  = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_WORD3  = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_LRU    = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_HIT    = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_MISS   = 8'h18;

   localparam int WEN_BIT = 31;
   localparam int IDX_LSB = 0;

   localparam logic             WEN_RESET = 1'b0;
   localparam logic [IDX_W-1:0] IDX_RESET = 4'h0;
   localparam logic [LRU_W-1:0] LRU_RESET = 25'h0000000;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed
   {
      logic valid;
      logic fetch;
      logic cacheable;
      logic hit;
   } pfc_access_t;

   typedef struct packed
   {
      logic                               valid;
      logic [IDX_W-1:0]                   index;
      logic [WORDS-1:0][DATA_W-1:0]       words;
   } pfc_fill_t;

   typedef struct packed
   {
      logic             valid;
      logic [LRU_W-1:0] state;
   } pfc_lru_t;

   function automatic logic [DATA_W-1:0] merge_bytes(
      input logic [DATA_W-1:0] old_val,
      input logic [DATA_W-1:0] new_val,
      input logic [3:0]        strb);
      logic [DATA_W-1:0] res;
      res = old_val;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
            res[b*8 +: 8] = new_val[b*8 +: 8];
      end
      return res;
   endfunction

endpackage

// file: verilog/pfc_counter.sv
`timescale 1ns/1ps
module pfc_counter
(
   input  wire logic                       aclk,
   input  wire logic                       load,
   input  wire logic [pfc_pkg::DATA_W-1:0] load_value,
   input  wire logic                       inc,
   output logic      [pfc_pkg::DATA_W-1:0] count
);

   logic [pfc_pkg::DATA_W-1:0] count_r;
   logic [pfc_pkg::DATA_W-1:0] count_nxt;

   // no reset: value is undefined until software loads it
   always_comb
   begin
      count_nxt = count_r;
      if (load)
         count_nxt = load_value;
      else if (inc)
         count_nxt = count_r + 32'h00000001;
   end

   always_ff @(posedge aclk)
   begin
      count_r <= count_nxt;
   end

   assign count = count_r;

endmodule

// file: verilog/pfc_line_store.sv
`timescale 1ns/1ps
module pfc_line_store
(
   input  wire logic                          aclk,
   input  wire logic                          sw_we,
   input  wire logic [1:0]                    sw_sel,
   input  wire logic [pfc_pkg::IDX_W-1:0]     sw_index,
   input  wire logic [pfc_pkg::DATA_W-1:0]    sw_wdata,
   input  pfc_pkg::pfc_fill_t                 fill,
   input  wire logic [pfc_pkg::IDX_W-1:0]     core_index,
   output logic [pfc_pkg::WORDS-1:0][pfc_pkg::DATA_W-1:0] sw_words,
   output logic [pfc_pkg::WORDS-1:0][pfc_pkg::DATA_W-1:0] core_words
);

   logic [pfc_pkg::LINES-1:0][pfc_pkg::WORDS-1:0][pfc_pkg::DATA_W-1:0]
      mem_r;
   logic [pfc_pkg::LINES-1:0][pfc_pkg::WORDS-1:0][pfc_pkg::DATA_W-1:0]
      mem_nxt;

   // software write lands after the fill so it wins on a collision
   always_comb
   begin
      mem_nxt = mem_r;
      if (fill.valid)
         mem_nxt[fill.index] = fill.words;
      if (sw_we)
         mem_nxt[sw_index][sw_sel] = sw_wdata;
   end

   always_ff @(posedge aclk)
   begin
      mem_r <= mem_nxt;
   end

   assign sw_words   = mem_r[sw_index];
   assign core_words = mem_r[core_index];

endmodule

// file: verilog/pfc_debug_window.sv
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
// Operation
// - word-one register windows line word 1
// - word-two register windows line word 2
// - word-three register windows line word 3
// - protected device reads window as zero
// - 25-bit replacement state, zero after reset
// - upper replacement bits read zero, ignore writes
// - hit counter counts cacheable fetch/load hits
// - hit counter 32-bit read/write, no reset
// - miss counter counts cacheable fetch misses
// - miss counter 32-bit read/write, no reset
// - 4-bit index selects the window line
// - window writes only with write enable set
module pfc_debug_window
(
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire logic [pfc_pkg::ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic [2:0]                    s_axi_awprot,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [pfc_pkg::DATA_W-1:0]    s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [pfc_pkg::ADDR_W-1:0]    s_axi_araddr,
   input  wire logic [2:0]                    s_axi_arprot,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [pfc_pkg::DATA_W-1:0]         s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  wire logic                          code_protect,
   input  pfc_pkg::pfc_access_t               core_access,
   input  pfc_pkg::pfc_fill_t                 line_fill,
   input  pfc_pkg::pfc_lru_t                  lru_update,
   input  wire logic [pfc_pkg::IDX_W-1:0]     core_index,
   output logic [pfc_pkg::WORDS-1:0][pfc_pkg::DATA_W-1:0] core_words
);

   typedef enum logic [1:0]
   {
      WR_IDLE   = 2'b00,
      WR_COMMIT = 2'b01,
      WR_RESP   = 2'b11
   } pfc_wr_state_t;

   typedef enum logic
   {
      RD_IDLE = 1'b0,
      RD_RESP = 1'b1
   } pfc_rd_state_t;

   ////////////////////////////////////////////////////////////////////////
   // write channel

   pfc_wr_state_t               wr_state_r;
   pfc_wr_state_t               wr_state_nxt;
   logic                        aw_held_r;
   logic                        aw_held_nxt;
   logic                        w_held_r;
   logic                        w_held_nxt;
   logic [pfc_pkg::ADDR_W-1:0]  wr_addr_r;
   logic [pfc_pkg::ADDR_W-1:0]  wr_addr_nxt;
   logic [pfc_pkg::DATA_W-1:0]  wr_data_r;
   logic [pfc_pkg::DATA_W-1:0]  wr_data_nxt;
   logic [3:0]                  wr_strb_r;
   logic [3:0]                  wr_strb_nxt;
   logic [1:0]                  bresp_r;
   logic [1:0]                  bresp_nxt;
   logic                        commit;

   assign commit        = (wr_state_r == WR_COMMIT);
   assign s_axi_awready = (wr_state_r == WR_IDLE) && !aw_held_r;
   assign s_axi_wready  = (wr_state_r == WR_IDLE) && !w_held_r;
   assign s_axi_bvalid  = (wr_state_r == WR_RESP);
   assign s_axi_bresp   = bresp_r;

   // address and data may arrive in either order
   always_comb
   begin
      wr_state_nxt = wr_state_r;
      aw_held_nxt  = aw_held_r;
      w_held_nxt   = w_held_r;
      wr_addr_nxt  = wr_addr_r;
      wr_data_nxt  = wr_data_r;
      wr_strb_nxt  = wr_strb_r;
      case (wr_state_r)
         WR_IDLE:
         begin
            if (s_axi_awvalid && s_axi_awready)
            begin
               aw_held_nxt = 1'b1;
               wr_addr_nxt = s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
               w_held_nxt  = 1'b1;
               wr_data_nxt = s_axi_wdata;
               wr_strb_nxt = s_axi_wstrb;
            end
            if (aw_held_nxt && w_held_nxt)
               wr_state_nxt = WR_COMMIT;
         end
         WR_COMMIT:
         begin
            aw_held_nxt  = 1'b0;
            w_held_nxt   = 1'b0;
            wr_state_nxt = WR_RESP;
         end
         WR_RESP:
         begin
            if (s_axi_bready)
               wr_state_nxt = WR_IDLE;
         end
         default:
            wr_state_nxt = WR_IDLE;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_state_r <= WR_IDLE;
         aw_held_r  <= 1'b0;
         w_held_r   <= 1'b0;
         wr_addr_r  <= '0;
         wr_data_r  <= '0;
         wr_strb_r  <= '0;
         bresp_r    <= pfc_pkg::RESP_OKAY;
      end
      else
      begin
         wr_state_r <= wr_state_nxt;
         aw_held_r  <= aw_held_nxt;
         w_held_r   <= w_held_nxt;
         wr_addr_r  <= wr_addr_nxt;
         wr_data_r  <= wr_data_nxt;
         wr_strb_r  <= wr_strb_nxt;
         bresp_r    <= bresp_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control and state registers

   logic                        wen_r;
   logic                        wen_nxt;
   logic [pfc_pkg::IDX_W-1:0]   index_r;
   logic [pfc_pkg::IDX_W-1:0]   index_nxt;
   logic [pfc_pkg::LRU_W-1:0]   lru_r;
   logic [pfc_pkg::LRU_W-1:0]   lru_nxt;
   logic [pfc_pkg::WORDS-1:0][pfc_pkg::DATA_W-1:0] sw_words;
   logic [pfc_pkg::DATA_W-1:0]  hit_count;
   logic [pfc_pkg::DATA_W-1:0]  miss_count;
   logic [pfc_pkg::DATA_W-1:0]  ctl_merged;
   logic                        store_we;
   logic [1:0]                  store_sel;
   logic [pfc_pkg::DATA_W-1:0]  store_wdata;
   logic                        hit_load;
   logic                        miss_load;
   logic                        hit_inc;
   logic                        miss_inc;
   logic                        win_addr;

   assign ctl_merged = pfc_pkg::merge_bytes(
      {wen_r, 27'h0000000, index_r}, wr_data_r, wr_strb_r);

   always_comb
   begin
      wen_nxt     = wen_r;
      index_nxt   = index_r;
      store_we    = 1'b0;
      store_sel   = 2'h0;
      win_addr    = 1'b0;
      hit_load    = 1'b0;
      miss_load   = 1'b0;
      bresp_nxt   = bresp_r;
      if (wr_addr_r == pfc_pkg::OFS_WORD1)
      begin
         win_addr  = 1'b1;
         store_sel = 2'h0;
      end
      else if (wr_addr_r == pfc_pkg::OFS_WORD2)
      begin
         win_addr  = 1'b1;
         store_sel = 2'h1;
      end
      else if (wr_addr_r == pfc_pkg::OFS_WORD3)
      begin
         win_addr  = 1'b1;
         store_sel = 2'h2;
      end
      store_wdata = pfc_pkg::merge_bytes(sw_words[store_sel], wr_data_r,
                                         wr_strb_r);
      if (commit)
      begin
         bresp_nxt = pfc_pkg::RESP_OKAY;
         if (wr_addr_r == pfc_pkg::OFS_ACCESS)
         begin
            wen_nxt   = ctl_merged[pfc_pkg::WEN_BIT];
            index_nxt = ctl_merged[pfc_pkg::IDX_LSB +: pfc_pkg::IDX_W];
         end
         else if (win_addr)
            store_we = wen_r;
         else if (wr_addr_r == pfc_pkg::OFS_LRU)
            bresp_nxt = pfc_pkg::RESP_OKAY;
         else if (wr_addr_r == pfc_pkg::OFS_HIT)
            hit_load = 1'b1;
         else if (wr_addr_r == pfc_pkg::OFS_MISS)
            miss_load = 1'b1;
         else
            bresp_nxt = pfc_pkg::RESP_SLVERR;
      end
   end

   // replacement state is owned by the cache, software only observes it
   assign lru_nxt = lru_update.valid ? lru_update.state : lru_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wen_r   <= pfc_pkg::WEN_RESET;
         index_r <= pfc_pkg::IDX_RESET;
         lru_r   <= pfc_pkg::LRU_RESET;
      end
      else
      begin
         wen_r   <= wen_nxt;
         index_r <= index_nxt;
         lru_r   <= lru_nxt;
      end
   end

   pfc_line_store u_store
   (
      .aclk       (aclk),
      .sw_we      (store_we),
      .sw_sel     (store_sel),
      .sw_index   (index_r),
      .sw_wdata   (store_wdata),
      .fill       (line_fill),
      .core_index (core_index),
      .sw_words   (sw_words),
      .core_words (core_words)
   );

   ////////////////////////////////////////////////////////////////////////
   // statistics counters

   assign hit_inc  = core_access.valid && core_access.cacheable &&
                     core_access.hit;
   assign miss_inc = core_access.valid && core_access.cacheable &&
                     !core_access.hit && core_access.fetch;

   pfc_counter u_hit
   (
      .aclk       (aclk),
      .load       (hit_load),
      .load_value (pfc_pkg::merge_bytes(hit_count, wr_data_r, wr_strb_r)),
      .inc        (hit_inc),
      .count      (hit_count)
   );

   pfc_counter u_miss
   (
      .aclk       (aclk),
      .load       (miss_load),
      .load_value (pfc_pkg::merge_bytes(miss_count, wr_data_r, wr_strb_r)),
      .inc        (miss_inc),
      .count      (miss_count)
   );

   ////////////////////////////////////////////////////////////////////////
   // read channel

   pfc_rd_state_t               rd_state_r;
   pfc_rd_state_t               rd_state_nxt;
   logic [pfc_pkg::DATA_W-1:0]  rdata_r;
   logic [pfc_pkg::DATA_W-1:0]  rdata_nxt;
   logic [1:0]                  rresp_r;
   logic [1:0]                  rresp_nxt;
   logic [pfc_pkg::DATA_W-1:0]  rd_value;
   logic [1:0]                  rd_resp;

   assign s_axi_arready = (rd_state_r == RD_IDLE);
   assign s_axi_rvalid  = (rd_state_r == RD_RESP);
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   // protected reads still complete, the array contents are masked
   always_comb
   begin
      rd_value = '0;
      rd_resp  = pfc_pkg::RESP_OKAY;
      if (s_axi_araddr == pfc_pkg::OFS_ACCESS)
         rd_value = {wen_r, 27'h0000000, index_r};
      else if (s_axi_araddr == pfc_pkg::OFS_WORD1)
         rd_value = code_protect ? '0 : sw_words[0];
      else if (s_axi_araddr == pfc_pkg::OFS_WORD2)
         rd_value = code_protect ? '0 : sw_words[1];
      else if (s_axi_araddr == pfc_pkg::OFS_WORD3)
         rd_value = code_protect ? '0 : sw_words[2];
      else if (s_axi_araddr == pfc_pkg::OFS_LRU)
         rd_value = {7'h00, lru_r};
      else if (s_axi_araddr == pfc_pkg::OFS_HIT)
         rd_value = hit_count;
      else if (s_axi_araddr == pfc_pkg::OFS_MISS)
         rd_value = miss_count;
      else
         rd_resp = pfc_pkg::RESP_SLVERR;
   end

   always_comb
   begin
      rd_state_nxt = rd_state_r;
      rdata_nxt    = rdata_r;
      rresp_nxt    = rresp_r;
      case (rd_state_r)
         RD_IDLE:
         begin
            if (s_axi_arvalid)
            begin
               rdata_nxt    = rd_value;
               rresp_nxt    = rd_resp;
               rd_state_nxt = RD_RESP;
            end
         end
         RD_RESP:
         begin
            if (s_axi_rready)
               rd_state_nxt = RD_IDLE;
         end
         default:
            rd_state_nxt = RD_IDLE;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rd_state_r <= RD_IDLE;
         rdata_r    <= '0;
         rresp_r    <= pfc_pkg::RESP_OKAY;
      end
      else
      begin
         rd_state_r <= rd_state_nxt;
         rdata_r    <= rdata_nxt;
         rresp_r    <= rresp_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   logic ar_take;
   assign ar_take = s_axi_arvalid && s_axi_arready;

   chk_word_one_map: assert property (
      @(posedge aclk) disable iff (!aresetn)
      commit && wen_r && wr_addr_r == pfc_pkg::OFS_WORD1 &&
      wr_strb_r == 4'hF
      |=> sw_words[0] == $past(wr_data_r))
      else $error("word one write not stored");

   chk_protect_read: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ar_take && code_protect &&
      (s_axi_araddr == pfc_pkg::OFS_WORD2 ||
       s_axi_araddr == pfc_pkg::OFS_WORD3)
      |=> s_axi_rvalid && s_axi_rdata == 32'h00000000)
      else $error("protected window read leaked data");

   chk_lru_read_value: assert property (
      @(posedge aclk) disable iff (!aresetn)
      ar_take && s_axi_araddr == pfc_pkg::OFS_LRU
      |=> s_axi_rdata[pfc_pkg::LRU_W-1:0] == $past(lru_r))
      else $error("replacement state read wrong");

   chk_lru_upper_zero: assert property (
      @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && $past(ar_take) &&
      $past(s_axi_araddr) == pfc_pkg::OFS_LRU
      |-> s_axi_rdata[31:25] == 7'h00)
      else $error("replacement upper bits not zero");

   chk_hit_count_inc: assert property (
      @(posedge aclk) disable iff (!aresetn)
      hit_inc && !hit_load
      |=> hit_count == $past(hit_count) + 32'h00000001)
      else $error("hit counter did not advance");

   chk_miss_load_quiet: assert property (
      @(posedge aclk) disable iff (!aresetn)
      core_access.valid && !core_access.fetch && !miss_load
      |=> $stable(miss_count))
      else $error("miss counter moved on a load");

   chk_gated_write: assert property (
      @(posedge aclk) disable iff (!aresetn)
      commit && !wen_r && win_addr && !line_fill.valid
      |=> $stable(sw_words))
      else $error("window written while disabled");

   chk_write_wins: assert property (
      @(posedge aclk) disable iff (!aresetn)
      miss_load && miss_inc && wr_strb_r == 4'hF
      |=> miss_count == $past(wr_data_r))
      else $error("increment overrode software write");

   chk_write_resp: assert property (
      @(posedge aclk) disable iff (!aresetn)
      commit |=> s_axi_bvalid [*1] ##0 s_axi_bresp == $past(bresp_nxt))
      else $error("write response missing");

endmodule

// file: tb/pfc_core_model.sv
`timescale 1ns/1ps
module pfc_core_model
(
   input  wire logic            aclk,
   input  pfc_pkg::pfc_access_t acc_req,
   input  pfc_pkg::pfc_fill_t   fill_req,
   input  pfc_pkg::pfc_lru_t    lru_req,
   output pfc_pkg::pfc_access_t core_access,
   output pfc_pkg::pfc_fill_t   line_fill,
   output pfc_pkg::pfc_lru_t    lru_update
);
   pfc_pkg::pfc_access_t idle_a;
   pfc_pkg::pfc_fill_t   idle_f;
   pfc_pkg::pfc_lru_t    idle_l;

   initial
   begin
      core_access = '0;
      line_fill   = '0;
      lru_update  = '0;
   end

   // idle payload flips each cycle so a stale field is never mistaken
   always @(posedge aclk)
   begin
      idle_a = ~core_access;
      idle_a.valid = 1'b0;
      idle_f = ~line_fill;
      idle_f.valid = 1'b0;
      idle_l = ~lru_update;
      idle_l.valid = 1'b0;
      core_access <= acc_req.valid ? acc_req : idle_a;
      line_fill   <= fill_req.valid ? fill_req : idle_f;
      lru_update  <= lru_req.valid ? lru_req : idle_l;
   end
endmodule

// file: tb/pfc_debug_window_tb.sv
`timescale 1ns/1ps
module pfc_debug_window_tb;
   logic                 aclk = 1'b0;
   logic                 aresetn;
   logic [7:0]           awaddr;
   logic                 awvalid;
   logic                 awready;
   logic [31:0]          wdata;
   logic [3:0]           wstrb;
   logic                 wvalid;
   logic                 wready;
   logic [1:0]           bresp;
   logic                 bvalid;
   logic                 bready;
   logic [7:0]           araddr;
   logic                 arvalid;
   logic                 arready;
   logic [31:0]          rdata;
   logic [1:0]           rresp;
   logic                 rvalid;
   logic                 rready;
   logic                 code_protect;
   logic [3:0]           core_index;
   pfc_pkg::pfc_access_t acc_req;
   pfc_pkg::pfc_fill_t   fill_req;
   pfc_pkg::pfc_lru_t    lru_req;
   pfc_pkg::pfc_access_t core_access;
   pfc_pkg::pfc_fill_t   line_fill;
   pfc_pkg::pfc_lru_t    lru_update;
   logic [pfc_pkg::WORDS-1:0][pfc_pkg::DATA_W-1:0] core_words;
   int                   n_errors = 0;
   int                   cmp_count = 0;
   int                   eh;
   int                   em;

   always #5 aclk = ~aclk;

   pfc_debug_window dut_u
   (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (awaddr),
      .s_axi_awprot  (3'h0),
      .s_axi_awvalid (awvalid),
      .s_axi_awready (awready),
      .s_axi_wdata   (wdata),
      .s_axi_wstrb   (wstrb),
      .s_axi_wvalid  (wvalid),
      .s_axi_wready  (wready),
      .s_axi_bresp   (bresp),
      .s_axi_bvalid  (bvalid),
      .s_axi_bready  (bready),
      .s_axi_araddr  (araddr),
      .s_axi_arprot  (3'h0),
      .s_axi_arvalid (arvalid),
      .s_axi_arready (arready),
      .s_axi_rdata   (rdata),
      .s_axi_rresp   (rresp),
      .s_axi_rvalid  (rvalid),
      .s_axi_rready  (rready),
      .code_protect  (code_protect),
      .core_access   (core_access),
      .line_fill     (line_fill),
      .lru_update    (lru_update),
      .core_index    (core_index),
      .core_words    (core_words)
   );

   pfc_core_model core_u
   (
      .aclk        (aclk),
      .acc_req     (acc_req),
      .fill_req    (fill_req),
      .lru_req     (lru_req),
      .core_access (core_access),
      .line_fill   (line_fill),
      .lru_update  (lru_update)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      if (n_errors == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   function automatic logic [31:0] pat(input int l, input int w);
      return {8'hC0 + 8'(w), 16'h5A3C, 8'(l)};
   endfunction

   function automatic logic [7:0] wa(input int w);
      return pfc_pkg::OFS_WORD1 + 8'(4*w);
   endfunction

   // ready is raised one edge late so it is never driven twice in a step
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (int i = 0; i < 40; i++)
      begin
         @(posedge aclk);
         if (bvalid === 1'b1 && bready === 1'b1)
         begin
            bready <= 1'b0;
            chk("bresp", {30'h0, er}, {30'h0, bresp});
            return;
         end
         if (awvalid === 1'b1 && awready === 1'b1)
            awvalid <= 1'b0;
         if (wvalid === 1'b1 && wready === 1'b1)
            wvalid <= 1'b0;
         bready <= 1'b1;
      end
      n_errors++;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [1:0] er,
                      input logic [31:0] ed);
      araddr <= a;
      arvalid <= 1'b1;
      for (int i = 0; i < 40; i++)
      begin
         @(posedge aclk);
         if (rvalid === 1'b1 && rready === 1'b1)
         begin
            rready <= 1'b0;
            chk("rresp", {30'h0, er}, {30'h0, rresp});
            chk("rdata", ed, rdata);
            return;
         end
         if (arvalid === 1'b1 && arready === 1'b1)
            arvalid <= 1'b0;
         rready <= 1'b1;
      end
      n_errors++;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      #200000;
      n_errors++;
      stop_test();
   end

   initial
   begin
      aresetn = 1'b0;
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready, code_protect, core_index} = '0;
      acc_req = '0;
      fill_req = '0;
      lru_req = '0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rdc(pfc_pkg::OFS_LRU, pfc_pkg::RESP_OKAY, 32'h0);
      rdc(8'h1C, pfc_pkg::RESP_SLVERR, 32'h0);
      wr(8'h1C, 32'hFFFFFFFF, 4'hF, pfc_pkg::RESP_SLVERR);
      for (int l = 5; l < 7; l++)
      begin
         wr(pfc_pkg::OFS_ACCESS, 32'h80000000 | l, 4'hF, 2'h0);
         for (int w = 0; w < 3; w++)
            wr(wa(w), pat(l, w), 4'hF, 2'h0);
      end
      // write enable off: reads still work, writes are dropped
      for (int l = 5; l < 7; l++)
      begin
         wr(pfc_pkg::OFS_ACCESS, 32'(l), 4'hF, 2'h0);
         for (int w = 0; w < 3; w++)
         begin
            rdc(wa(w), 2'h0, pat(l, w));
            wr(wa(w), 32'h0, 4'hF, 2'h0);
            rdc(wa(w), 2'h0, pat(l, w));
         end
      end
      core_index <= 4'h5;
      repeat (2) @(posedge aclk);
      for (int w = 0; w < 3; w++)
         chk("core_words", pat(5, w), core_words[w]);
      fill_req <= '{valid: 1'b1, index: 4'h7,
                    words: {32'h3333CCCC, 32'h2222DDDD, 32'h1111EEEE}};
      @(posedge aclk);
      fill_req.valid <= 1'b0;
      // unused control bits must be dropped, only enable and index kept
      wr(pfc_pkg::OFS_ACCESS, 32'hFFFFFFF7, 4'hF, 2'h0);
      rdc(pfc_pkg::OFS_ACCESS, 2'h0, 32'h80000007);
      rdc(pfc_pkg::OFS_WORD1, 2'h0, 32'h1111EEEE);
      rdc(pfc_pkg::OFS_WORD2, 2'h0, 32'h2222DDDD);
      rdc(pfc_pkg::OFS_WORD3, 2'h0, 32'h3333CCCC);
      wr(pfc_pkg::OFS_WORD1, 32'hFFFFFFFF, 4'h2, 2'h0);
      rdc(pfc_pkg::OFS_WORD1, 2'h0, 32'h1111FFEE);
      code_protect <= 1'b1;
      for (int w = 0; w < 3; w++)
         rdc(wa(w), 2'h0, 32'h0);
      code_protect <= 1'b0;
      rdc(pfc_pkg::OFS_WORD3, 2'h0, 32'h3333CCCC);
      lru_req <= '{valid: 1'b1, state: 25'h1ABCDEF};
      @(posedge aclk);
      lru_req.valid <= 1'b0;
      // the pulse reaches the block one edge after the model sees it
      @(posedge aclk);
      rdc(pfc_pkg::OFS_LRU, 2'h0, 32'h01ABCDEF);
      wr(pfc_pkg::OFS_LRU, 32'hFFFFFFFF, 4'hF, 2'h0);
      rdc(pfc_pkg::OFS_LRU, 2'h0, 32'h01ABCDEF);
      wr(pfc_pkg::OFS_HIT, 32'h0, 4'hF, 2'h0);
      wr(pfc_pkg::OFS_MISS, 32'h0, 4'hF, 2'h0);
      // every valid/fetch/cacheable/hit mix, back to back
      eh = 0;
      em = 0;
      for (int k = 0; k < 16; k++)
      begin
         acc_req <= pfc_pkg::pfc_access_t'(4'(k));
         eh += (k[3] & k[1] & k[0]);
         em += (k[3] & k[2] & k[1] & ~k[0]);
         @(posedge aclk);
      end
      acc_req <= '0;
      repeat (3) @(posedge aclk);
      rdc(pfc_pkg::OFS_HIT, 2'h0, 32'(eh));
      rdc(pfc_pkg::OFS_MISS, 2'h0, 32'(em));
      wr(pfc_pkg::OFS_HIT, 32'hFFFFFFFF, 4'hF, 2'h0);
      wr(pfc_pkg::OFS_MISS, 32'hFFFFFFFF, 4'hF, 2'h0);
      acc_req <= pfc_pkg::pfc_access_t'(4'hF);
      @(posedge aclk);
      acc_req <= pfc_pkg::pfc_access_t'(4'hE);
      @(posedge aclk);
      acc_req <= '0;
      repeat (3) @(posedge aclk);
      rdc(pfc_pkg::OFS_HIT, 2'h0, 32'h0);
      rdc(pfc_pkg::OFS_MISS, 2'h0, 32'h0);
      // misses every cycle: load at commit wins, then two more counted
      acc_req <= pfc_pkg::pfc_access_t'(4'hE);
      wr(pfc_pkg::OFS_MISS, 32'h00000100, 4'hF, 2'h0);
      acc_req <= '0;
      repeat (3) @(posedge aclk);
      rdc(pfc_pkg::OFS_MISS, 2'h0, 32'h00000102);
      stop_test();
   end
endmodule
